// *** src/bobe_cfg.svh ***
// Offsets, field positions and reset values of the byte-op execution block
`ifndef BOBE_CFG_SVH
`define BOBE_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define BOBE_OFF_INSTR   8'h00
`define BOBE_OFF_ACC     8'h04
`define BOBE_OFF_STATUS  8'h08
`define BOBE_OFF_PC      8'h0c
`define BOBE_OFF_LATCH   8'h10
`define BOBE_OFF_FADDR   8'h14
`define BOBE_OFF_FDATA   8'h18
`define BOBE_OFF_CYCLES  8'h1c

// ****************************************************************
// Instruction word fields
// ****************************************************************
`define BOBE_OP_HI       14
`define BOBE_OP_LO       12
`define BOBE_DEST_BIT    7
`define BOBE_FADDR_HI    6
`define BOBE_LIT_HI      10
`define BOBE_LIT8_HI     7

// ****************************************************************
// Status bits and latch field feeding the upper PC bits
// ****************************************************************
`define BOBE_ST_ZERO     0
`define BOBE_ST_BUSY     1
`define BOBE_ST_SKIP     2
`define BOBE_LATCH_HI    4
`define BOBE_LATCH_LO    3

// ****************************************************************
// Reset values
// ****************************************************************
`define BOBE_ACC_RST     8'h00
`define BOBE_ZERO_RST    1'b0
`define BOBE_PC_RST      13'h0000
`define BOBE_LATCH_RST   8'h00
`define BOBE_INSTR_RST   32'h0000_0000

// ****************************************************************
// Bus responses
// ****************************************************************
`define BOBE_RESP_OKAY   2'h0
`define BOBE_RESP_DECERR 2'h3

`endif

// *** src/bobe_pkg.sv ***
// Types shared by the byte-op execution block
package bobe_pkg;

  typedef enum logic [2:0] {
    OP_NOP                    = 3'h0,
    OP_CLEAR_FILE_REG         = 3'h1,
    OP_DECREMENT_FILE         = 3'h2,
    OP_CLEAR_ACCUMULATOR      = 3'h3,
    OP_DECREMENT_SKIP_ZERO    = 3'h4,
    OP_INCREMENT_SKIP_ZERO    = 3'h5,
    OP_UNCONDITIONAL_JUMP     = 3'h6,
    OP_OR_LITERAL_ACCUMULATOR = 3'h7
  } bobe_op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_FLUSH
  } bobe_phase_type;

  typedef enum logic [3:0] {
    RG_NONE,
    RG_INSTR,
    RG_ACC,
    RG_STATUS,
    RG_PC,
    RG_LATCH,
    RG_FADDR,
    RG_FDATA,
    RG_CYCLES
  } bobe_reg_type;

  typedef struct packed {
    bobe_phase_type        phase;
    logic [31:0]           instr;
    logic [7:0]            acc;
    logic                  zero;
    logic                  skip_last;
    logic [12:0]           pc;
    logic [7:0]            latch;
    logic [6:0]            faddr;
    logic [127:0][7:0]     file;
    logic [15:0]           cycles;
    logic                  aw_got;
    logic [7:0]            aw_addr;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } bobe_core_type;

endpackage

// *** src/bobe_alu.sv ***
// Result, flag and sequencing decode for one instruction
`timescale 1ns/100ps
`include "bobe_cfg.svh"

module bobe_alu
  import bobe_pkg::*;
(
  input  wire bobe_op_type op,
  input  wire logic        dest_file,
  input  wire logic [7:0]  file_val,
  input  wire logic [7:0]  acc_val,
  input  wire logic [7:0]  literal,
  output logic      [7:0]  result,
  output logic             wr_acc,
  output logic             wr_file,
  output logic             z_update,
  output logic             zero,
  output logic             skip,
  output logic             jump
);

  always_comb begin
    result   = 8'h00;
    wr_acc   = 1'b0;
    wr_file  = 1'b0;
    z_update = 1'b0;
    skip     = 1'b0;
    jump     = 1'b0;
    unique case (op)
      OP_NOP: begin
      end
      OP_CLEAR_FILE_REG: begin
        result   = 8'h00;
        wr_file  = 1'b1;
        z_update = 1'b1;
      end
      OP_DECREMENT_FILE: begin
        result   = file_val - 8'h01;
        wr_acc   = ~dest_file;
        wr_file  = dest_file;
        z_update = 1'b1;
      end
      OP_CLEAR_ACCUMULATOR: begin
        result   = 8'h00;
        wr_acc   = 1'b1;
        z_update = 1'b1;
      end
      OP_DECREMENT_SKIP_ZERO: begin
        result   = file_val - 8'h01;
        wr_acc   = ~dest_file;
        wr_file  = dest_file;
        skip     = (result == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO: begin
        result   = file_val + 8'h01;
        wr_acc   = ~dest_file;
        wr_file  = dest_file;
        skip     = (result == 8'h00);
      end
      OP_UNCONDITIONAL_JUMP: begin
        jump     = 1'b1;
      end
      OP_OR_LITERAL_ACCUMULATOR: begin
        result   = acc_val | literal;
        wr_acc   = 1'b1;
        z_update = 1'b1;
      end
    endcase
  end

  // Only sampled when z_update is set
  assign zero = (result == 8'h00);

endmodule

// *** src/bobe_exec.sv ***
// Byte-op execution core with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "bobe_cfg.svh"

// How it works
// - Clearing a file register writes zero into it and sets the zero flag.
// - Decrement-file stores register minus one to acc or back, updates flag.
// - Clearing the accumulator loads zero into it and sets the zero flag.
// - Decrement-skip stores minus one, keeps flags, skips on zero result.
// - Increment-skip stores plus one, keeps flags, skips on zero result.
// - The jump loads the 11-bit literal low and latch bits 4:3 high.
// - The jump always takes two cycles, the second doing no work.
// - OR-literal ors an 8-bit immediate into acc and updates the flag.
// - A skip not taken finishes in one cycle and the next runs normally.
module bobe_exec
  import bobe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             exec_busy
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic bobe_reg_type bobe_sel(input logic [7:0] addr);
    logic [7:0] base;
    base = {addr[7:2], 2'b00};
    unique case (base)
      `BOBE_OFF_INSTR:  bobe_sel = RG_INSTR;
      `BOBE_OFF_ACC:    bobe_sel = RG_ACC;
      `BOBE_OFF_STATUS: bobe_sel = RG_STATUS;
      `BOBE_OFF_PC:     bobe_sel = RG_PC;
      `BOBE_OFF_LATCH:  bobe_sel = RG_LATCH;
      `BOBE_OFF_FADDR:  bobe_sel = RG_FADDR;
      `BOBE_OFF_FDATA:  bobe_sel = RG_FDATA;
      `BOBE_OFF_CYCLES: bobe_sel = RG_CYCLES;
      default:          bobe_sel = RG_NONE;
    endcase
  endfunction

  function automatic logic [31:0] bobe_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    bobe_merge = res;
  endfunction

  // A taken skip also steps over the squashed slot
  function automatic logic [12:0] bobe_pc_next(input logic [12:0] pc,
                                               input logic [7:0]  latch,
                                               input logic [10:0] lit,
                                               input logic        jump,
                                               input logic        skip);
    logic [12:0] nxt;
    nxt = pc + 13'h0001;
    if (jump) begin
      nxt = {latch[`BOBE_LATCH_HI:`BOBE_LATCH_LO], lit};
    end else if (skip) begin
      nxt = pc + 13'h0002;
    end
    bobe_pc_next = nxt;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  bobe_core_type s_q;
  bobe_core_type s_d;

  bobe_op_type   cur_op;
  logic [6:0]    cur_f;
  logic [7:0]    alu_result;
  logic          alu_wr_acc;
  logic          alu_wr_file;
  logic          alu_z_update;
  logic          alu_zero;
  logic          alu_skip;
  logic          alu_jump;
  logic          commit;

  // ****************************************************************
  // Instruction decode
  // ****************************************************************

  assign cur_op = bobe_op_type'(s_q.instr[`BOBE_OP_HI:`BOBE_OP_LO]);
  assign cur_f  = s_q.instr[`BOBE_FADDR_HI:0];

  bobe_alu u_alu (
    .op        (cur_op),
    .dest_file (s_q.instr[`BOBE_DEST_BIT]),
    .file_val  (s_q.file[cur_f]),
    .acc_val   (s_q.acc),
    .literal   (s_q.instr[`BOBE_LIT8_HI:0]),
    .result    (alu_result),
    .wr_acc    (alu_wr_acc),
    .wr_file   (alu_wr_file),
    .z_update  (alu_z_update),
    .zero      (alu_zero),
    .skip      (alu_skip),
    .jump      (alu_jump)
  );

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  // Writes wait while an instruction runs, so state never races software
  assign commit = s_q.aw_got && s_q.w_got && !s_q.bvalid &&
                  (s_q.phase == ST_IDLE);

  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign exec_busy     = (s_q.phase != ST_IDLE);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0]  rd;
    logic [31:0]  wm;
    bobe_reg_type rsel;
    bobe_reg_type wsel;
    rd   = 32'h0000_0000;
    wm   = 32'h0000_0000;
    rsel = bobe_sel(s_axi_araddr);
    wsel = bobe_sel(s_q.aw_addr);
    s_d  = s_q;

    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // Read mux
    unique case (rsel)
      RG_INSTR:  rd = s_q.instr;
      RG_ACC:    rd = {24'h000000, s_q.acc};
      RG_STATUS: begin
        rd[`BOBE_ST_ZERO] = s_q.zero;
        rd[`BOBE_ST_BUSY] = (s_q.phase != ST_IDLE);
        rd[`BOBE_ST_SKIP] = s_q.skip_last;
      end
      RG_PC:     rd = {19'h00000, s_q.pc};
      RG_LATCH:  rd = {24'h000000, s_q.latch};
      RG_FADDR:  rd = {25'h0000000, s_q.faddr};
      RG_FDATA:  rd = {24'h000000, s_q.file[s_q.faddr]};
      RG_CYCLES: rd = {16'h0000, s_q.cycles};
      RG_NONE:   rd = 32'h0000_0000;
    endcase
    // Answer is frozen at the address handshake, so it cannot tear
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd;
      s_d.rresp  = (rsel == RG_NONE) ? `BOBE_RESP_DECERR : `BOBE_RESP_OKAY;
    end

    // Commit only from idle; a write stays parked in the held flags
    // until the running instruction has retired
    unique case (s_q.phase)
      ST_IDLE: begin
        if (commit) begin
          s_d.aw_got = 1'b0;
          s_d.w_got  = 1'b0;
          s_d.bvalid = 1'b1;
          s_d.bresp  = `BOBE_RESP_OKAY;
          unique case (wsel)
            RG_INSTR: begin
              s_d.instr = bobe_merge(s_q.instr, s_q.wdata, s_q.wstrb);
              s_d.phase = ST_EXEC;
            end
            RG_ACC: begin
              wm        = bobe_merge({24'h000000, s_q.acc}, s_q.wdata,
                                     s_q.wstrb);
              s_d.acc   = wm[7:0];
            end
            RG_STATUS: begin
              if (s_q.wstrb[0]) begin
                s_d.zero = s_q.wdata[`BOBE_ST_ZERO];
              end
            end
            RG_PC: begin
              wm        = bobe_merge({19'h00000, s_q.pc}, s_q.wdata,
                                     s_q.wstrb);
              s_d.pc    = wm[12:0];
            end
            RG_LATCH: begin
              wm        = bobe_merge({24'h000000, s_q.latch}, s_q.wdata,
                                     s_q.wstrb);
              s_d.latch = wm[7:0];
            end
            RG_FADDR: begin
              if (s_q.wstrb[0]) begin
                s_d.faddr = s_q.wdata[6:0];
              end
            end
            RG_FDATA: begin
              if (s_q.wstrb[0]) begin
                s_d.file[s_q.faddr] = s_q.wdata[7:0];
              end
            end
            RG_CYCLES: begin
              // Counter is read-only; write acknowledged and dropped
            end
            RG_NONE: begin
              s_d.bresp = `BOBE_RESP_DECERR;
            end
          endcase
        end
      end
      ST_EXEC: begin
        if (alu_wr_acc) begin
          s_d.acc = alu_result;
        end
        if (alu_wr_file) begin
          s_d.file[cur_f] = alu_result;
        end
        if (alu_z_update) begin
          s_d.zero = alu_zero;
        end
        s_d.skip_last = alu_skip;
        s_d.pc = bobe_pc_next(s_q.pc, s_q.latch,
                              s_q.instr[`BOBE_LIT_HI:0],
                              alu_jump, alu_skip);
        // Second cycle is a dead slot: nothing but the counter moves
        s_d.phase  = (alu_jump || alu_skip) ? ST_FLUSH : ST_IDLE;
        s_d.cycles = s_q.cycles + 16'h0001;
      end
      ST_FLUSH: begin
        // Squashed slot: only the counter moves; a parked write waits for idle
        s_d.phase  = ST_IDLE;
        s_d.cycles = s_q.cycles + 16'h0001;
      end
      default: begin
        s_d.phase = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q       <= '0;
      s_q.phase <= ST_IDLE;
      s_q.instr <= `BOBE_INSTR_RST;
      s_q.acc   <= `BOBE_ACC_RST;
      s_q.zero  <= `BOBE_ZERO_RST;
      s_q.pc    <= `BOBE_PC_RST;
      s_q.latch <= `BOBE_LATCH_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// *** verif/bobe_exec_chk.sv ***
// Port-level assertions of the byte-op execution block
`timescale 1ns/100ps

module bobe_exec_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        exec_busy
);
  // Last taken address and data, so a commit can be tied to its op
  logic [7:0]  aw_q;
  logic [31:0] w_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_q <= 8'h00;
      w_q  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence instr_commit;
    $rose(s_axi_bvalid) && aw_q == 8'h00;
  endsequence
  sequence one_cycle_op;
    instr_commit ##0 w_q[14:12] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  endsequence
  sequence jump_op;
    instr_commit ##0 w_q[14:12] == 3'h6;
  endsequence

  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer moved");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  a_w_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready early");
  a_unmapped_err: assert property ($rose(s_axi_bvalid) && aw_q > 8'h1c
    |-> s_axi_bresp == 2'h3) else $error("no decode error");
  a_jump_two: assert property (jump_op |->
    exec_busy ##1 exec_busy ##1 !exec_busy) else $error("jump length");
  a_plain_one: assert property (one_cycle_op |->
    exec_busy ##1 !exec_busy) else $error("op length");
  a_busy_bound: assert property ($rose(exec_busy) |->
    ##[1:2] !exec_busy) else $error("busy too long");
endmodule

bind bobe_exec bobe_exec_chk i_chk (.*);

// *** verif/tb.sv ***
// Self-checking bench of the byte-op execution block
`timescale 1ns/100ps

module tb;
  logic        clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, c0;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [63:0] r;
  int          n_errors, samples_checked, cyc;
  integer      seed;

  bobe_exec i_bobe_exec (.*);

  always #20 clk = ~clk;

  task automatic end_sim;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end

  // Random back-pressure; ready only drops after a handshake
  always @(posedge clk) begin
    if (!s_axi_bready || s_axi_bvalid) s_axi_bready <= 1'($random(seed));
    if (!s_axi_rready || s_axi_rvalid) s_axi_rready <= 1'($random(seed));
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    rsp = s_axi_bresp;
  endtask

  task automatic rg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  function automatic void model(input logic [2:0] op,
      input logic [10:0] k, input logic [7:0] f, a, input logic z,
      input logic [12:0] pc, input logic [7:0] lt,
      output logic [7:0] ef, ea, output logic ez, sk,
      output logic [12:0] ep, output logic [1:0] n);
    logic [7:0] v;
    ef = f;
    ea = a;
    ez = z;
    sk = 1'b0;
    ep = pc + 13'h1;
    n = 2'h1;
    v = (op == 3'h5) ? f + 8'h1 : f - 8'h1;
    case (op)
      3'h1: begin ef = 8'h00; ez = 1'b1; end
      3'h3: begin ea = 8'h00; ez = 1'b1; end
      3'h6: begin ep = {lt[4:3], k}; n = 2'h2; end
      3'h7: begin ea = a | k[7:0]; ez = (ea == 8'h00); end
      3'h2, 3'h4, 3'h5: begin
        if (k[7]) ef = v;
        else ea = v;
        if (op == 3'h2) ez = (v == 8'h00);
        else if (v == 8'h00) begin sk = 1'b1; ep = pc + 13'h2; n = 2'h2; end
      end
      default: ;
    endcase
  endfunction

  task automatic run_op(input logic [2:0] op, input logic [10:0] k,
      input logic [7:0] f, a, input logic z, input logic [12:0] pc,
      input logic [7:0] lt);
    logic [7:0]  ef, ea;
    logic        ez, sk;
    logic [12:0] ep;
    logic [1:0]  n;
    model(op, k, f, a, z, pc, lt, ef, ea, ez, sk, ep, n);
    wr(8'h14, {25'h0, k[6:0]});
    wr(8'h18, {24'h0, f});
    wr(8'h04, {24'h0, a});
    wr(8'h08, {31'h0, z});
    wr(8'h0c, {19'h0, pc});
    wr(8'h10, {24'h0, lt});
    rg(8'h1c);
    c0 = rd;
    wr(8'h00, {17'h0, op, 1'b0, k});
    chk({30'h0, rsp}, 32'h0, "instr resp");
    while (exec_busy) @(posedge clk);
    rg(8'h04);
    chk(rd, {24'h0, ea}, "acc");
    chk({30'h0, rsp}, 32'h0, "acc resp");
    rg(8'h08);
    chk(rd & (op[2] && !op[1] ? 32'h7 : 32'h3),
        {29'h0, sk, 1'b0, ez}, "status");
    rg(8'h0c);
    chk(rd, {19'h0, ep}, "pc");
    rg(8'h18);
    chk(rd, {24'h0, ef}, "file");
    rg(8'h1c);
    chk(rd, c0 + {30'h0, n}, "cycles");
  endtask

  initial begin
    seed = 32'hc4bc0066;
    {clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    n_errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rg(8'h0c);
    chk(rd, 32'h0, "pc reset");
    run_op(3'h4, 11'h0aa, 8'h01, 8'h5a, 1'b1, 13'h1ffe, 8'h00);
    run_op(3'h4, 11'h02a, 8'h02, 8'h5a, 1'b0, 13'h0010, 8'h00);
    run_op(3'h5, 11'h0b3, 8'hff, 8'h11, 1'b0, 13'h0020, 8'h00);
    run_op(3'h5, 11'h033, 8'h00, 8'h11, 1'b1, 13'h0030, 8'h00);
    run_op(3'h2, 11'h011, 8'h01, 8'h33, 1'b0, 13'h0040, 8'h00);
    run_op(3'h2, 11'h091, 8'h00, 8'h33, 1'b1, 13'h0050, 8'h00);
    run_op(3'h1, 11'h07f, 8'ha5, 8'h44, 1'b0, 13'h0060, 8'h00);
    run_op(3'h3, 11'h000, 8'h12, 8'hff, 1'b0, 13'h0070, 8'h00);
    run_op(3'h6, 11'h7ff, 8'h12, 8'h01, 1'b0, 13'h0000, 8'h18);
    run_op(3'h6, 11'h000, 8'h12, 8'h01, 1'b1, 13'h1fff, 8'he7);
    run_op(3'h7, 11'h000, 8'h12, 8'h00, 1'b0, 13'h0080, 8'h00);
    run_op(3'h7, 11'h0ff, 8'h12, 8'h00, 1'b1, 13'h0090, 8'h00);
    run_op(3'h0, 11'h000, 8'h12, 8'h00, 1'b1, 13'h00a0, 8'h00);
    repeat (40) begin
      r = {$random(seed), $random(seed)};
      run_op(r[2:0], r[13:3], r[21:14], r[29:22], r[30], r[43:31], r[51:44]);
    end
    // Second write commits only after the jump has already retired
    wr(8'h10, 32'h08);
    rg(8'h1c);
    c0 = rd;
    wr(8'h00, 32'h6100);
    wr(8'h00, 32'h0);
    while (exec_busy) @(posedge clk);
    rg(8'h0c);
    chk(rd, 32'h0901, "pc after pair");
    rg(8'h1c);
    chk(rd, c0 + 32'h3, "cycles after pair");
    wr(8'h1c, 32'h0);
    rg(8'h1c);
    chk(rd, c0 + 32'h3, "cycles read only");
    wr(8'h20, 32'hffff_ffff);
    chk({30'h0, rsp}, 32'h3, "write decode");
    rg(8'hfc);
    chk({rd[31:2], rsp}, 32'h3, "read decode");
    // Lane 0 masked off: the accumulator byte must survive
    wr(8'h04, 32'h0000_005a);
    s_axi_wstrb <= 4'he;
    wr(8'h04, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    rg(8'h04);
    chk(rd, 32'h0000_005a, "masked lane");
    end_sim();
  end
endmodule
